// File: rar_params.svh
// Offsets, field positions and reset values of the remote alias and link status slice
`ifndef RAR_PARAMS_SVH
`define RAR_PARAMS_SVH

// Register indices; byte address is four times the index
`define RAR_IDX_CTRL 6'h04
`define RAR_IDX_TARGET 6'h07
`define RAR_IDX_ALIAS 6'h08
`define RAR_IDX_CNT_LO 6'h0a
`define RAR_IDX_CNT_HI 6'h0b
`define RAR_IDX_STATUS 6'h0c
`define RAR_IDX_PORTSEL 6'h10

// Field positions
`define RAR_CTRL_CRC_RST 5
`define RAR_ST_LOST 4
`define RAR_ST_SELFTEST 3
`define RAR_ST_CLOCK 2
`define RAR_ST_RXERR 1
`define RAR_ST_DETECT 0
`define RAR_PORTSEL_BIT 0

// Reset values and limits
`define RAR_ADDR_RESET 7'h00
`define RAR_ADDR_ZERO 7'h00
`define RAR_CNT_RESET 16'h0000
`define RAR_CNT_MAX 16'hffff
`define RAR_CNT_ONE 16'h0001
`define RAR_DATA_ZERO 32'h0000_0000

`endif

// File: rar_pkg.sv
// Types shared by the remote alias and link status slice
package rar_pkg;

  typedef struct packed {
    logic [1:0][6:0] alias_addr;
    logic [1:0][6:0] target_addr;
    logic [1:0][15:0] crc_count;
    logic [1:0] link_lost;
    logic [1:0] selftest_crc_error;
    logic [1:0] rx_error;
    logic [1:0] detect_prev;
    logic second_port_select;
    logic ack;
    logic [31:0] rdata;
  } rar_state_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } rar_sync_t;

  typedef struct packed {
    logic fwd_valid;
    logic [6:0] fwd_addr;
    logic blocked;
  } rar_remap_t;

endpackage

// File: rar_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module rar_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Level in and out
  input wire logic async_i,
  output logic sync_o
);
  import rar_pkg::*;

  rar_sync_t st;
  rar_sync_t next_st;

  // First stage is read only by the second stage
  always_comb begin
    next_st = st;
    next_st.stage1 = async_i;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stage2;

endmodule // rar_sync

`default_nettype wire

// File: rar_remap.sv
// Alias to remote target address substitution for one port
`timescale 1ns/1ps
`default_nettype none
`include "rar_params.svh"

module rar_remap (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Local transaction address
  input wire logic req_valid_i,
  input wire logic [6:0] req_addr_i,
  // Configured addresses
  input wire logic [6:0] alias_i,
  input wire logic [6:0] target_i,
  // Forwarded transaction
  output logic fwd_valid_o,
  output logic [6:0] fwd_addr_o,
  output logic blocked_o
);
  import rar_pkg::*;

  rar_remap_t st;
  rar_remap_t next_st;
  logic hit;
  logic enabled;

  always_comb begin
    next_st = st;
    hit = req_valid_i && (req_addr_i == alias_i);
    enabled = (alias_i != `RAR_ADDR_ZERO) && (target_i != `RAR_ADDR_ZERO);
    next_st.fwd_valid = hit && enabled;
    next_st.blocked = hit && !enabled;
    if (hit && enabled) begin
      next_st.fwd_addr = target_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fwd_valid_o = st.fwd_valid;
  assign fwd_addr_o = st.fwd_addr;
  assign blocked_o = st.blocked;

endmodule // rar_remap

`default_nettype wire

// File: rar_top.sv
// Remote alias mapping and link status register slice, Wishbone slave
//
// Operation
// - A local transaction hitting the alias is forwarded with the remote target address.
// - A 7-bit alias sits in bits 7..1 and is compared with local addresses.
// - A zero alias or zero target blocks all access to that remote target.
// - A 16-bit read-only CRC error count, low byte then high byte.
// - The CRC error reset bit clears both counter bytes.
// - Link loss sets a sticky flag held until CRC error reset.
// - Self-test CRC errors set a flag; link loss, restart or reset clear it.
// - Input clock status shows a valid video clock, independent of port select.
// - Normal-traffic CRC errors set a flag; link loss or reset clear it.
// - Link detect shows the live cable link of the selected port.
// - Port select steers per-port reads and writes to the second port's copies.
`timescale 1ns/1ps
`default_nettype none
`include "rar_params.svh"

module rar_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link events per port, from control channel logic on this clock
  input wire logic [1:0] crc_error_i,
  input wire logic [1:0] selftest_active_i,
  input wire logic [1:0] selftest_restart_i,
  // Asynchronous status levels
  input wire logic [1:0] link_detect_i,
  input wire logic input_clock_present_i,
  // Local I2C address to remap
  input wire logic req_valid_i,
  input wire logic [6:0] req_addr_i,
  // Forwarded transaction per port
  output logic [1:0] fwd_valid_o,
  output logic [1:0][6:0] fwd_addr_o,
  output logic [1:0] blocked_o
);
  import rar_pkg::*;

  // ********************
  // Functions
  // ********************

  // Merge an address field from the low byte lane; bit 0 is reserved
  function automatic logic [6:0] merge_addr(input logic [6:0] old_val,
                                            input logic [31:0] data,
                                            input logic [3:0] sel);
    logic [6:0] res;
    res = old_val;
    if (sel[0]) begin
      res = data[7:1];
    end
    return res;
  endfunction

  // Register index decode, used for reads and writes
  function automatic logic is_index(input logic [7:0] adr,
                                    input logic [5:0] idx);
    return adr[7:2] == idx;
  endfunction

  // Next counter value; saturating, clear then count
  function automatic logic [15:0] next_count(input logic [15:0] cur,
                                             input logic clr,
                                             input logic inc);
    logic [15:0] base;
    logic [15:0] res;
    base = clr ? `RAR_CNT_RESET : cur;
    res = base;
    if (inc && (base != `RAR_CNT_MAX)) begin
      res = base + `RAR_CNT_ONE;
    end
    return res;
  endfunction

  // ********************
  // Synchronisers
  // ********************

  logic [1:0] detect_sync;
  logic clock_sync;

  // Link detect comes from the analog front end, not this clock
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_det
      rar_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(link_detect_i[gp]),
        .sync_o(detect_sync[gp])
      );
    end
  endgenerate

  rar_sync u_clk_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(input_clock_present_i),
    .sync_o(clock_sync)
  );

  // ********************
  // State
  // ********************

  rar_state_t st;
  rar_state_t next_st;

  logic access;
  logic wr_now;
  logic port;
  logic crc_reset;
  logic [1:0] link_loss;
  logic [31:0] rd_val;
  logic [7:0] status_byte;

  // ********************
  // Bus decode
  // ********************

  always_comb begin
    access = wb_cyc_i && wb_stb_i;
    // A write lands at the edge where the master sees ack
    wr_now = access && wb_we_i && st.ack;
    port = st.second_port_select;
    crc_reset = wr_now && is_index(wb_adr_i, `RAR_IDX_CTRL) && wb_sel_i[0]
                && wb_dat_i[`RAR_CTRL_CRC_RST];
  end

  // ********************
  // Read mux
  // ********************

  always_comb begin
    status_byte = 8'h00;
    status_byte[`RAR_ST_LOST] = st.link_lost[port];
    status_byte[`RAR_ST_SELFTEST] = st.selftest_crc_error[port];
    status_byte[`RAR_ST_CLOCK] = clock_sync;
    status_byte[`RAR_ST_RXERR] = st.rx_error[port];
    status_byte[`RAR_ST_DETECT] = detect_sync[port];

    rd_val = `RAR_DATA_ZERO;
    if (is_index(wb_adr_i, `RAR_IDX_TARGET)) begin
      rd_val[7:1] = st.target_addr[port];
    end else if (is_index(wb_adr_i, `RAR_IDX_ALIAS)) begin
      rd_val[7:1] = st.alias_addr[port];
    end else if (is_index(wb_adr_i, `RAR_IDX_CNT_LO)) begin
      rd_val[7:0] = st.crc_count[port][7:0];
    end else if (is_index(wb_adr_i, `RAR_IDX_CNT_HI)) begin
      rd_val[7:0] = st.crc_count[port][15:8];
    end else if (is_index(wb_adr_i, `RAR_IDX_STATUS)) begin
      rd_val[7:0] = status_byte;
    end else if (is_index(wb_adr_i, `RAR_IDX_PORTSEL)) begin
      rd_val[`RAR_PORTSEL_BIT] = st.second_port_select;
    end
  end

  // ********************
  // Next state
  // ********************

  always_comb begin
    next_st = st;

    // One-cycle ack, dropped the cycle after; unmapped reads return zero
    next_st.ack = access && !st.ack;
    if (access && !st.ack) begin
      next_st.rdata = rd_val;
    end

    // Configuration writes; per-port target and alias, shared port select
    if (wr_now) begin
      if (is_index(wb_adr_i, `RAR_IDX_TARGET)) begin
        next_st.target_addr[port] = merge_addr(st.target_addr[port], wb_dat_i, wb_sel_i);
      end
      if (is_index(wb_adr_i, `RAR_IDX_ALIAS)) begin
        next_st.alias_addr[port] = merge_addr(st.alias_addr[port], wb_dat_i, wb_sel_i);
      end
      if (is_index(wb_adr_i, `RAR_IDX_PORTSEL) && wb_sel_i[0]) begin
        next_st.second_port_select = wb_dat_i[`RAR_PORTSEL_BIT];
      end
    end

    // Per-port link events; hardware set wins over any clear
    for (int p = 0; p < 2; p++) begin
      next_st.detect_prev[p] = detect_sync[p];
      link_loss[p] = st.detect_prev[p] && !detect_sync[p];

      next_st.crc_count[p] = next_count(st.crc_count[p], crc_reset, crc_error_i[p]);

      if (crc_reset) begin
        next_st.link_lost[p] = 1'b0;
      end
      if (link_loss[p]) begin
        next_st.link_lost[p] = 1'b1;
      end

      if (crc_reset || link_loss[p] || selftest_restart_i[p]) begin
        next_st.selftest_crc_error[p] = 1'b0;
      end
      if (crc_error_i[p] && selftest_active_i[p]) begin
        next_st.selftest_crc_error[p] = 1'b1;
      end

      if (crc_reset || link_loss[p]) begin
        next_st.rx_error[p] = 1'b0;
      end
      if (crc_error_i[p] && !selftest_active_i[p]) begin
        next_st.rx_error[p] = 1'b1;
      end
    end
  end

  // ********************
  // Registers
  // ********************

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.alias_addr <= {2{`RAR_ADDR_RESET}};
      st.target_addr <= {2{`RAR_ADDR_RESET}};
      st.crc_count <= {2{`RAR_CNT_RESET}};
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;

  // ********************
  // Address remapping
  // ********************

  // Both ports see the same local address; each applies its own alias
  generate
    for (gp = 0; gp < 2; gp++) begin : g_map
      rar_remap u_remap (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_valid_i(req_valid_i),
        .req_addr_i(req_addr_i),
        .alias_i(st.alias_addr[gp]),
        .target_i(st.target_addr[gp]),
        .fwd_valid_o(fwd_valid_o[gp]),
        .fwd_addr_o(fwd_addr_o[gp]),
        .blocked_o(blocked_o[gp])
      );
    end
  endgenerate

endmodule // rar_top

`default_nettype wire

// File: rar_sva.sv
// Checker for the bus, remap and status ports of the slice
`timescale 1ns/1ps
`default_nettype none
module rar_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Link events and levels
  input wire logic [1:0] crc_error_i,
  input wire logic [1:0] selftest_active_i,
  input wire logic [1:0] selftest_restart_i,
  input wire logic [1:0] link_detect_i,
  input wire logic input_clock_present_i,
  // Remap
  input wire logic req_valid_i,
  input wire logic [6:0] req_addr_i,
  input wire logic [1:0] fwd_valid_o,
  input wire logic [1:0][6:0] fwd_addr_o,
  input wire logic [1:0] blocked_o
);
  // Cycles the video clock level has been steady; the synchroniser hides fresh changes
  logic ckq;
  logic [3:0] sc;
  always_ff @(posedge clk_i) begin
    ckq <= input_clock_present_i;
    sc <= (rst_i || ckq != input_clock_present_i) ? 4'h0 : sc + {3'h0, sc != 4'hf};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved between answers");
  status_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h0c && sc > 4'h6
    |-> wb_dat_o[7:5] == 3'h0 && wb_dat_o[2] == input_clock_present_i)
    else $error("status clock bit or reserved bits wrong");
  fwd_idle_a: assert property (!$past(req_valid_i) |-> fwd_valid_o == 2'b00 && blocked_o == 2'b00)
    else $error("remap output without request");
  fwd_excl_a: assert property ((fwd_valid_o & blocked_o) == 2'b00)
    else $error("forwarded and blocked together");
  fwd_addr_a: assert property (fwd_valid_o[0] |-> fwd_addr_o[0] != 7'h00)
    else $error("forwarded to zero address");
  cv_fwd: cover property (fwd_valid_o[1]);
  cv_blk: cover property (blocked_o[0]);
  cv_rd: cover property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h0c);
endmodule // rar_sva
`default_nettype wire

// File: rar_link_model.sv
// Far-end model: cable detect, back-channel CRC events, self-test, video clock
`timescale 1ns/1ps
`default_nettype none
module rar_link_model (
  // Clock
  input wire logic clk_i,
  // Events and levels toward the slice
  output logic [1:0] crc_error_o,
  output logic [1:0] selftest_active_o,
  output logic [1:0] selftest_restart_o,
  output logic [1:0] link_detect_o,
  output logic input_clock_present_o
);
  initial begin
    crc_error_o = 2'h0;
    selftest_active_o = 2'h0;
    selftest_restart_o = 2'h0;
    link_detect_o = 2'h3;
    input_clock_present_o = 1'b1;
  end
  // n back-to-back CRC errors, inside self-test when st is set
  task automatic errs(input int p, input int n, input logic st);
    @(posedge clk_i);
    selftest_active_o[p] <= st;
    repeat (n) begin
      @(posedge clk_i);
      crc_error_o[p] <= 1'b1;
    end
    @(posedge clk_i);
    crc_error_o[p] <= 1'b0;
    selftest_active_o[p] <= 1'b0;
  endtask
  task automatic restart(input int p);
    @(posedge clk_i);
    selftest_restart_o[p] <= 1'b1;
    @(posedge clk_i);
    selftest_restart_o[p] <= 1'b0;
  endtask
  // Port 2 means the video clock; waits out the synchroniser
  task automatic lvl(input int p, input logic v);
    @(posedge clk_i);
    if (p == 2) input_clock_present_o <= v;
    else link_detect_o[p] <= v;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // rar_link_model
`default_nettype wire

// File: remote_alias_link_status_regs_test.sv
// Self-checking bench for the remote alias and link status slice
`timescale 1ns/1ps
`default_nettype none
`include "rar_params.svh"
module remote_alias_link_status_regs_test;
  import rar_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, req_valid_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic [3:0] wb_sel_i = 0;
  logic [6:0] req_addr_i = 0, a0, a1, t0, t1;
  logic [1:0] crc_error_i, selftest_active_i, selftest_restart_i, link_detect_i;
  logic [1:0] fwd_valid_o, blocked_o;
  logic [1:0][6:0] fwd_addr_o;
  logic wb_ack_o, input_clock_present_i;
  logic [31:0] rq[$], fq[$];
  int err_count = 0, tests_run = 0, cyc_n = 0, s;
  always #2.5 clk_i = ~clk_i;
  rar_top uut (.*);
  rar_link_model m (.clk_i(clk_i), .crc_error_o(crc_error_i),
    .selftest_active_o(selftest_active_i), .selftest_restart_o(selftest_restart_i),
    .link_detect_o(link_detect_i), .input_clock_present_o(input_clock_present_i));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d, input logic [3:0] sl);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, sl};
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 4'hf);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    rq.push_back({24'h0, e});
    bus(1'b0, i, 8'h00, 4'hf);
  endtask
  task automatic req(input logic [6:0] a, input logic [31:0] e);
    if (e != 0) fq.push_back(e);
    @(posedge clk_i);
    {req_valid_i, req_addr_i} <= {1'b1, a};
    @(posedge clk_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************
  // Result watcher
  // ****************
  always @(posedge clk_i) begin
    cyc_n++;
    if (wb_ack_o === 1'b1 && !wb_we_i) chk(wb_dat_o, rq.pop_front());
    if ((fwd_valid_o | blocked_o) !== 2'b00) chk({14'h0, blocked_o, fwd_valid_o,
      fwd_valid_o[1] ? fwd_addr_o[1] : 7'h00, fwd_valid_o[0] ? fwd_addr_o[0] : 7'h00},
      fq.pop_front());
    if (cyc_n == 90000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    s = $urandom(32'h1f887ef6);
    {a0, a1} = {3'h1, 4'($urandom), 3'h2, 4'($urandom)};
    {t0, t1} = {1'b1, 6'($urandom), 1'b1, 6'($urandom)};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int k = 0; k < 8; k++) rd(6'(k * 5 + 4), 8'h00);
    rd(`RAR_IDX_STATUS, 8'h05);
    wr(`RAR_IDX_TARGET, {t0, 1'b1});
    wr(`RAR_IDX_ALIAS, {a0, 1'b1});
    wr(`RAR_IDX_PORTSEL, 8'h01);
    wr(`RAR_IDX_TARGET, {t1, 1'b1});
    wr(`RAR_IDX_ALIAS, {a1, 1'b1});
    rd(`RAR_IDX_TARGET, {t1, 1'b0});
    wr(`RAR_IDX_PORTSEL, 8'h00);
    bus(1'b1, `RAR_IDX_ALIAS, 8'h02, 4'he);
    rd(`RAR_IDX_ALIAS, {a0, 1'b0});
    wr(`RAR_IDX_CNT_LO, 8'hff);
    rd(`RAR_IDX_CNT_LO, 8'h00);
    req(a0, {18'h1, 7'h0, t0});
    req(a1, {18'h2, t1, 7'h0});
    req(a0 ^ 7'h40, 0);
    wr(`RAR_IDX_TARGET, 8'h00);
    req(a0, {18'h4, 14'h0});
    m.errs(1, 5, 1'b0);
    wr(`RAR_IDX_PORTSEL, 8'h01);
    rd(`RAR_IDX_CNT_LO, 8'h05);
    rd(`RAR_IDX_STATUS, 8'h07);
    wr(`RAR_IDX_PORTSEL, 8'h00);
    m.errs(0, 3, 1'b1);
    rd(`RAR_IDX_STATUS, 8'h0d);
    m.restart(0);
    rd(`RAR_IDX_STATUS, 8'h05);
    m.errs(0, 2, 1'b0);
    m.lvl(0, 1'b0);
    rd(`RAR_IDX_STATUS, 8'h14);
    m.lvl(0, 1'b1);
    m.lvl(2, 1'b0);
    rd(`RAR_IDX_STATUS, 8'h11);
    m.lvl(2, 1'b1);
    wr(`RAR_IDX_CTRL, 8'h20);
    rd(`RAR_IDX_STATUS, 8'h05);
    rd(`RAR_IDX_CNT_LO, 8'h00);
    // Long burst: costs most of the run, but saturation has no shortcut
    m.errs(1, 65540, 1'b0);
    wr(`RAR_IDX_PORTSEL, 8'h01);
    rd(`RAR_IDX_CNT_LO, 8'hff);
    rd(`RAR_IDX_CNT_HI, 8'hff);
    test_done();
  end
endmodule // remote_alias_link_status_regs_test
bind rar_top rar_sva chk_i (.*);
`default_nettype wire
